// ===== logic/scan_packet_codec.sv
/*
 * Shift-scan packet decoder and sequencer with TDO response packing.
 * Takes command bytes from a command FIFO, drives the scan chain through
 * the link-side driver and pushes captured TDO bytes to a response FIFO.
 * Assumes valid/ready FIFO ports on mclk and a separate link clock.
 */
// Operation
// - Top three opcode bits 100 mark a shift-scan packet.
// - Final scan cycle drives TMS equal to opcode bit 3.
// - Normal length byte: bits 6..0 hold length minus one, 1 to 128.
// - Normal format, data TDI: data bytes follow the length byte.
// - Normal format, fixed TDI: packet ends at the length byte.
// - Length bit 7 set: packed format, length byte ends the packet.
// - Packed: highest set bit n among bits 6..1 gives n cycles.
// - Packed, data TDI: bit 0 drives first cycle, then upward.
// - Packed, fixed TDI: packed bits only set the scan length.
// - TDI data shifts least significant bit first, byte by byte.
// - Capture on: sample TDO every cycle, push each full byte.
// - Return ceil(length/8) bytes, first bit in bit 0, zero padding.
// - Scan pauses with TCK held while response byte cannot be pushed.
// - Capture off: nothing is pushed for the scan.
// - Opcode bit 0 selects data TDI or constant level from bit 1.
// - TMS stays low on every cycle before the final one.
`timescale 1ns/1ps
`default_nettype none
`include "scan_consts.svh"

module scan_packet_codec
    import scan_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    input wire logic rsp_ready,
    output logic busy,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);

    // ------------------------------------------------------------------
    // Packed length decode
    // ------------------------------------------------------------------
    // A packed byte with no flag among bits 6..1 is malformed; it is run
    // as a single cycle so the engine never stalls on it.
    function automatic logic [7:0] packed_len(input logic [7:0] b);
        logic [7:0] len;
        len = `LEN_PACKED_NONE;
        for (int i = `LEN_PACKED_LOW; i <= `LEN_PACKED_TOP; i++) begin
            if (b[i]) begin
                len = 8'(i);
            end
        end
        return len;
    endfunction

    // Only normal format with data TDI takes bytes after the length byte.
    function automatic logic data_fed(input logic fixed_sel,
                                      input logic packed_fmt);
        return !fixed_sel && !packed_fmt;
    endfunction

    eng_regs_t r;
    eng_regs_t n;
    logic ack_tgl;
    logic tdo_bit;
    logic take;
    logic ack_evt;
    logic [7:0] rem_after;
    logic [7:0] rsp_bit;

    // ------------------------------------------------------------------
    // Link-side driver
    // ------------------------------------------------------------------
    scan_link_phy scan_link_phy_inst (
        .link_clk(link_clk),
        .rst_b(rst_b),
        .req_tgl(r.req),
        .tms_in(r.tms_out),
        .tdi_in(r.tdi_out),
        .ack_tgl(ack_tgl),
        .tdo_bit(tdo_bit),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        take = cmd_valid && r.cmd_ready;
        n.ack_s1 = ack_tgl;
        n.ack_s2 = r.ack_s1;
        ack_evt = r.ack_s2 != r.ack_seen;
        rem_after = r.remaining - 8'h01;
        rsp_bit = 8'h00;
        rsp_bit[r.bit_idx] = tdo_bit;
        unique case (r.st)
            ST_HDR: begin
                // Other packet types are consumed and dropped here.
                if (take && cmd_data[`OP_ID_HI:`OP_ID_LO] == `OP_ID_SCAN) begin
                    n.tms_last = cmd_data[`OP_TMS_LAST_BIT];
                    n.capture = cmd_data[`OP_CAPTURE_BIT];
                    n.fixed_val = cmd_data[`OP_FIXED_VAL_BIT];
                    n.fixed_sel = cmd_data[`OP_FIXED_SEL_BIT];
                    n.st = ST_LEN;
                end
            end
            ST_LEN: begin
                if (take) begin
                    n.bit_idx = 3'h0;
                    n.rsp_sh = 8'h00;
                    n.data = cmd_data;
                    if (cmd_data[`LEN_PACKED_BIT]) begin
                        n.packed_fmt = 1'b1;
                        n.remaining = packed_len(cmd_data);
                        n.st = ST_BIT;
                    end else begin
                        n.packed_fmt = 1'b0;
                        n.remaining = {1'b0,
                            cmd_data[`LEN_FIELD_HI:0]} + 8'h01;
                        n.st = r.fixed_sel ? ST_BIT : ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                // Padding bits of a short last byte are never shifted out.
                if (take) begin
                    n.data = cmd_data;
                    n.st = ST_BIT;
                end
            end
            ST_BIT: begin
                if (!r.pending) begin
                    n.pending = 1'b1;
                    n.req = ~r.req;
                    n.tms_out = (r.remaining == 8'h01) ? r.tms_last
                                                       : 1'b0;
                    n.tdi_out = r.fixed_sel ? r.fixed_val
                                            : r.data[0];
                end else if (ack_evt) begin
                    n.ack_seen = r.ack_s2;
                    n.pending = 1'b0;
                    n.data = r.data >> 1;
                    n.remaining = rem_after;
                    n.bit_idx = r.bit_idx + 3'h1;
                    if (r.capture) begin
                        n.rsp_sh = r.rsp_sh | rsp_bit;
                    end
                    if (r.capture && (r.bit_idx == `BYTE_LAST_BIT
                            || rem_after == 8'h00)) begin
                        n.rsp_valid = 1'b1;
                        n.rsp_data = r.rsp_sh | rsp_bit;
                        n.st = ST_PUSH;
                    end else if (rem_after == 8'h00) begin
                        n.st = ST_HDR;
                    end else if (data_fed(r.fixed_sel, r.packed_fmt)
                            && r.bit_idx == `BYTE_LAST_BIT) begin
                        n.st = ST_DATA;
                    end
                end
            end
            ST_PUSH: begin
                // No new request is issued here, so TCK rests low.
                if (rsp_ready) begin
                    n.rsp_valid = 1'b0;
                    n.rsp_sh = 8'h00;
                    if (r.remaining == 8'h00) begin
                        n.st = ST_HDR;
                    end else if (data_fed(r.fixed_sel, r.packed_fmt)) begin
                        n.st = ST_DATA;
                    end else begin
                        n.st = ST_BIT;
                    end
                end
            end
            default: begin
                n.st = ST_HDR;
            end
        endcase
        n.cmd_ready = (n.st == ST_HDR) || (n.st == ST_LEN)
                      || (n.st == ST_DATA);
        n.busy = n.st != ST_HDR;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign cmd_ready = r.cmd_ready;
    assign rsp_valid = r.rsp_valid;
    assign rsp_data = r.rsp_data;
    assign busy = r.busy;

endmodule // scan_packet_codec

`default_nettype wire

// ===== logic/scan_consts.svh
/*
 * Constants of the shift-scan packet codec: opcode fields, length byte
 * layout, packet identifier and link timing counts.
 * Assumes it is included by its bare name from the codec and link modules.
 */
`ifndef SCAN_CONSTS_SVH
`define SCAN_CONSTS_SVH

// ----------------------------------------------------------------------
// Opcode byte fields
// ----------------------------------------------------------------------
`define OP_ID_HI 7
`define OP_ID_LO 5
`define OP_ID_SCAN 3'h4
`define OP_TMS_LAST_BIT 3
`define OP_CAPTURE_BIT 2
`define OP_FIXED_VAL_BIT 1
`define OP_FIXED_SEL_BIT 0

// ----------------------------------------------------------------------
// Length byte fields
// ----------------------------------------------------------------------
`define LEN_PACKED_BIT 7
`define LEN_FIELD_HI 6
`define LEN_PACKED_TOP 6
`define LEN_PACKED_LOW 1
`define LEN_PACKED_NONE 8'h01

// ----------------------------------------------------------------------
// Byte packing and link timing
// ----------------------------------------------------------------------
`define BYTE_LAST_BIT 3'h7
`define PHY_HIGH_WAIT 2'h3

`endif

// ===== logic/scan_pkg.sv
/*
 * Types of the shift-scan packet codec: state enumerations and the
 * packed register sets of the engine and of the link-side driver.
 * Assumes scan_consts.svh is on the include path.
 */
`default_nettype none
package scan_pkg;

    typedef enum logic [2:0] {
        ST_HDR,
        ST_LEN,
        ST_DATA,
        ST_BIT,
        ST_PUSH
    } scan_state_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SETUP,
        PH_HIGH
    } phy_state_t;

    typedef struct packed {
        scan_state_t st;
        logic cmd_ready;
        logic tms_last;
        logic capture;
        logic fixed_sel;
        logic fixed_val;
        logic packed_fmt;
        logic [7:0] remaining;
        logic [2:0] bit_idx;
        logic [7:0] data;
        logic [7:0] rsp_sh;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic req;
        logic pending;
        logic tms_out;
        logic tdi_out;
        logic ack_s1;
        logic ack_s2;
        logic ack_seen;
        logic busy;
    } eng_regs_t;

    typedef struct packed {
        phy_state_t st;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic tdo_s1;
        logic tdo_s2;
        logic tck;
        logic tms;
        logic tdi;
        logic tdo_bit;
        logic ack;
        logic [1:0] wait_cnt;
    } phy_regs_t;

endpackage

`default_nettype wire

// ===== logic/scan_link_phy.sv
/*
 * Link-side driver of one scan cycle: runs on the link clock, takes a
 * toggle request carrying stable TMS and TDI levels, makes one TCK pulse
 * and returns the sampled TDO with a toggle acknowledge.
 * Assumes the requester holds tms_in and tdi_in steady until the
 * acknowledge toggles, and that TDO changes only after TCK falls.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scan_consts.svh"

module scan_link_phy
    import scan_pkg::*;
(
    input wire logic link_clk,
    input wire logic rst_b,
    input wire logic req_tgl,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic ack_tgl,
    output logic tdo_bit,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);

    phy_regs_t r;
    phy_regs_t n;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.req_s1 = req_tgl;
        n.req_s2 = r.req_s1;
        n.tdo_s1 = tdo;
        n.tdo_s2 = r.tdo_s1;
        unique case (r.st)
            PH_IDLE: begin
                // TCK rests low here, so a stalled scan simply idles.
                if (r.req_s2 != r.req_seen) begin
                    n.req_seen = r.req_s2;
                    n.tms = tms_in;
                    n.tdi = tdi_in;
                    n.st = PH_SETUP;
                end
            end
            PH_SETUP: begin
                n.tck = 1'b1;
                n.wait_cnt = `PHY_HIGH_WAIT;
                n.st = PH_HIGH;
            end
            PH_HIGH: begin
                // The wait covers the TDO synchroniser delay.
                if (r.wait_cnt == 2'h0) begin
                    n.tdo_bit = r.tdo_s2;
                    n.tck = 1'b0;
                    n.ack = ~r.ack;
                    n.st = PH_IDLE;
                end else begin
                    n.wait_cnt = r.wait_cnt - 2'h1;
                end
            end
            default: begin
                n.st = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign ack_tgl = r.ack;
    assign tdo_bit = r.tdo_bit;
    assign tck = r.tck;
    assign tms = r.tms;
    assign tdi = r.tdi;

endmodule // scan_link_phy

`default_nettype wire

// ===== tb/chain_model.sv
/* Target scan chain model: one inverting stage between TDI and TDO.
   Assumes TCK rests low and TDO is read only while TCK is high. */
`timescale 1ns/1ps
`default_nettype none
module chain_model
    import scan_pkg::*;
(
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo
);
    // ----
    // Chain
    // ----
    logic tms_q[$];
    logic tdi_q[$];
    logic cap_r = 1'b0;
    logic out_r = 1'b0;
    assign tdo = out_r;
    always @(posedge tck) begin
        tms_q.push_back(tms);
        tdi_q.push_back(tdi);
        cap_r <= tdi;
    end
    // TDO moves only on falling TCK; the inversion shows a stuck input.
    always @(negedge tck) begin
        out_r <= ~cap_r;
    end
endmodule // chain_model
`default_nettype wire

// ===== tb/scan_codec_chk.sv
/* Port checker of the scan packet codec, bound to the top module.
   Assumes rst_b resets both clock domains. */
`timescale 1ns/1ps
`default_nettype none
module scan_codec_chk
    import scan_pkg::*;
(
    input wire logic mclk,
    input wire logic link_clk,
    input wire logic rst_b,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_ready,
    input wire logic busy,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi
);
    // ----
    // Properties
    // ----
    // Six link samples of stall rule out a request already in flight.
    wire stalled = rsp_valid & ~rsp_ready;
    chk_tck_width: assert property (@(posedge link_clk)
        disable iff (!rst_b) $rose(tck) |-> tck[*4] ##1 !tck)
        else $error("tck pulse width off");
    chk_tms_steady: assert property (@(posedge link_clk)
        disable iff (!rst_b) tck |-> $stable(tms))
        else $error("tms moved while tck high");
    chk_tdi_steady: assert property (@(posedge link_clk)
        disable iff (!rst_b) tck |-> $stable(tdi))
        else $error("tdi moved while tck high");
    chk_tck_in_pkt: assert property (@(posedge link_clk)
        disable iff (!rst_b) tck |-> busy)
        else $error("tck outside packet");
    chk_stall_tck: assert property (@(posedge link_clk)
        disable iff (!rst_b) stalled[*6] |-> !$rose(tck))
        else $error("tck pulse during stall");
    chk_rsp_hold: assert property (@(posedge mclk)
        disable iff (!rst_b) stalled |=> rsp_valid && $stable(rsp_data))
        else $error("response dropped while stalled");
    chk_rsp_once: assert property (@(posedge mclk)
        disable iff (!rst_b) rsp_valid && rsp_ready |=> !rsp_valid)
        else $error("response offered twice");
    chk_rsp_in_scan: assert property (@(posedge mclk)
        disable iff (!rst_b) $rose(rsp_valid) |-> $past(busy))
        else $error("response outside scan");
endmodule // scan_codec_chk
bind scan_packet_codec scan_codec_chk scan_codec_chk_inst (
    .mclk(mclk), .link_clk(link_clk), .rst_b(rst_b),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
    .busy(busy), .tck(tck), .tms(tms), .tdi(tdi)
);
`default_nettype wire

// ===== tb/tb_scan_packet_codec.sv
/* Bench of the scan packet codec: packet tasks with expected bits.
   Assumes the chain model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_scan_packet_codec
    import scan_pkg::*;
;
    localparam int LIM = 5000;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic rsp_ready = 1'b0;
    logic cmd_ready, rsp_valid, busy, tck, tms, tdi, tdo;
    logic [7:0] rsp_data;
    logic last_o = 1'b0;
    logic last_tms = 1'b0;
    int n_errors = 0;
    int checked = 0;
    always #25 mclk = ~mclk;
    always #32 link_clk = ~link_clk;
    scan_packet_codec scan_packet_codec_inst (
        .mclk(mclk), .rst_b(rst_b), .link_clk(link_clk),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
        .busy(busy), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo)
    );
    chain_model chain_model_inst (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo)
    );
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, want);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic expire(input int j);
        if (j >= LIM) begin
            n_errors++;
            close_out();
        end
    endtask
    task automatic send(input logic [7:0] b);
        int j;
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_data = b;
        j = 0;
        while (cmd_ready !== 1'b1 && j < LIM) begin
            @(negedge mclk);
            j++;
        end
        expire(j);
        @(posedge mclk);
    endtask
    task automatic take(input int nb, input logic [127:0] r, input bit stl);
        int j;
        int c;
        for (int k = 0; k < nb; k++) begin
            j = 0;
            while (rsp_valid !== 1'b1 && j < LIM) begin
                @(negedge mclk);
                j++;
            end
            expire(j);
            if (stl && k == 0) begin
                c = chain_model_inst.tdi_q.size();
                repeat (30) @(negedge mclk);
                chk(chain_model_inst.tdi_q.size(), c);
                chk(cmd_ready, 1'b0);
            end
            chk(rsp_data, r[8 * k +: 8]);
            rsp_ready = 1'b1;
            @(negedge mclk);
            rsp_ready = 1'b0;
        end
    endtask
    // Expected TDO follows the model: each bit is the inverted TDI before.
    task automatic run(input logic [7:0] op, input logic [7:0] lb,
                       input int n, input logic [127:0] v, input bit stl);
        int nb;
        int j;
        logic [127:0] e;
        logic [127:0] r;
        nb = (n + 7) / 8;
        for (int i = 0; i < 128; i++) begin
            e[i] = (i >= n) ? 1'b0 : (op[0] ? op[1] : v[i]);
            r[i] = (i >= n) ? 1'b0 : (i == 0 ? last_o : ~e[i - 1]);
        end
        chain_model_inst.tms_q.delete();
        chain_model_inst.tdi_q.delete();
        fork
            begin
                send(op);
                send(lb);
                if (!lb[7] && !op[0]) begin
                    @(negedge mclk);
                    cmd_valid = 1'b0;
                    repeat (20) @(negedge mclk);
                    chk(chain_model_inst.tdi_q.size(), 0);
                    for (j = 0; j < nb; j++) begin
                        send(e[8 * j +: 8]);
                    end
                end
                @(negedge mclk);
                cmd_valid = 1'b0;
            end
            if (op[2]) take(nb, r, stl);
        join
        j = 0;
        while (busy !== 1'b0 && j < LIM) begin
            @(negedge mclk);
            j++;
        end
        expire(j);
        repeat (10) @(negedge mclk);
        chk(rsp_valid, 1'b0);
        chk(chain_model_inst.tdi_q.size(), n);
        for (int i = 0; i < n; i++) begin
            chk(chain_model_inst.tdi_q[i], e[i]);
            if (i == n - 1) begin
                chk(chain_model_inst.tms_q[i], op[3]);
            end else if (!last_tms) begin
                chk(chain_model_inst.tms_q[i], 1'b0);
            end
        end
        last_tms = op[3];
        last_o = ~e[n - 1];
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        repeat (5) @(negedge mclk);
        rst_b = 1'b1;
        repeat (2) @(negedge mclk);
        chk(cmd_ready, 1'b1);
        run(8'h8C, 8'h14, 21, 128'h15A3C7, 1'b1);
        run(8'h83, 8'h04, 5, 128'h0, 1'b0);
        run(8'h84, 8'hAD, 5, 128'h0D, 1'b0);
        send(8'h20);
        send(8'h5F);
        @(negedge mclk);
        cmd_valid = 1'b0;
        repeat (20) @(negedge mclk);
        chk(chain_model_inst.tdi_q.size(), 5);
        chk(busy, 1'b0);
        run(8'h81, 8'h8F, 3, 128'h0, 1'b0);
        run(8'h8C, 8'h7F, 128, {4{32'hC3A59E17}}, 1'b0);
        run(8'h86, 8'h07, 8, 128'hB4, 1'b0);
        run(8'h87, 8'h80, 1, 128'h0, 1'b0);
        run(8'h80, 8'h00, 1, 128'h1, 1'b0);
        close_out();
    end
endmodule // tb_scan_packet_codec
`default_nettype wire
